// >>> logic/owc_map.svh
`ifndef OWC_MAP_SVH
`define OWC_MAP_SVH

// Block base and printed register locations (word indices, not bytes)
`define OWC_BASE 32'h50000000
`define OWC_OFF_FAST_OSC 32'h50000022
`define OWC_OFF_LOWFREQ 32'h50000024
`define OWC_OFF_REF_TRIM 32'h50000028
`define OWC_OFF_ANA_STAT 32'h5000002a
`define OWC_OFF_WAKE_CTRL 32'h50000100
`define OWC_OFF_WAKE_THR 32'h50000102
`define OWC_OFF_IRQ_CLR 32'h50000104
`define OWC_OFF_WAKE_CNT 32'h50000106
`define OWC_OFF_CNT_CLR 32'h50000108
`define OWC_OFF_WAKE_SEL 32'h5000010a
`define OWC_OFF_WAKE_POL 32'h50000112
// Byte address on the bus is four times the index within the block
`define OWC_ADDR(off) (((off) - `OWC_BASE) << 2)

// Writable bit masks; reserved bits read zero
`define OWC_FAST_MASK 16'h03ff
`define OWC_LOWF_MASK 16'h1fff
`define OWC_REF_MASK 16'h7fff
`define OWC_WCTRL_MASK 16'h00ff
`define OWC_BYTE_MASK 16'h00ff

// Reset values
`define OWC_FAST_RST 16'h00a0
`define OWC_LOWF_RST 16'h0178
`define OWC_REF_RST 16'h0000
`define OWC_WCTRL_RST 16'h0000
`define OWC_BYTE_RST 8'h00
`define OWC_STAT_RST 9'h090

// Fast oscillator word fields
`define OWC_FO_NOISE 9
`define OWC_FO_HOLD 8
`define OWC_FO_CUR 7:5
`define OWC_FO_RCTRIM 4:1
`define OWC_FO_RCEN 0
// Low-frequency RC word fields
`define OWC_LF_SEL 12
`define OWC_LF_EN 11
`define OWC_LF_LOW 10
`define OWC_LF_BIAS 9:8
`define OWC_LF_TEMP 7:4
`define OWC_LF_TRIM 3:0
// Reference word fields
`define OWC_RF_SHUT 14
`define OWC_RF_RET 13:10
`define OWC_RF_IBIAS 9:5
`define OWC_RF_VTRIM 4:0
// Wake control fields
`define OWC_WC_IRQEN 7
`define OWC_WC_KEY 6
`define OWC_WC_DEB 5:0

// Debounce time base
`define OWC_CLK_PERIOD_NS 8
`define OWC_DEB_UNIT_NS 1000000

`endif

// >>> logic/owc_pkg.sv
package owc_pkg;

  // Analog control outputs towards the oscillators and regulators
  typedef struct packed {
    logic xo_noise_filter_en;
    logic xo_bias_hold_en;
    logic [2:0] xo_bias_current;
    logic [3:0] fast_rc_freq_trim;
    logic fast_rc_en;
    logic slow_source_select;
    logic slow_rc_x_en;
    logic slow_rc_x_extra_low;
    logic [1:0] slow_rc_x_bias;
    logic [3:0] slow_rc_x_temp_ctrl;
    logic [3:0] slow_rc_x_freq_trim;
    logic ref_core_shutdown_test;
    logic [3:0] retention_reg_trim;
    logic [4:0] ref_bias_current_trim;
    logic [4:0] ref_voltage_trim;
  } owc_osc_ctrl_t;

  // Raw asynchronous health flags from the analog side
  typedef struct packed {
    logic boost_active;
    logic ref_ok;
    logic boost_batt_ok;
    logic adc_reg_ok;
    logic core_reg_ok;
    logic otp_reg_ok;
    logic conv_out_ok;
    logic batt_1v_above_thr;
    logic batt_1v_present;
  } owc_ana_raw_t;

  // Whole register and wakeup state of the block
  typedef struct packed {
    logic [15:0] fast_osc_config;
    logic [15:0] lowfreq_rc_config;
    logic [15:0] reference_trim;
    logic [15:0] wake_control;
    logic [7:0] wake_event_threshold;
    logic [7:0] wake_select;
    logic [7:0] wake_edge_polarity;
    logic [7:0] wake_count;
    logic wake_irq;
    logic key_prev;
    logic deb_pending;
    logic [5:0] deb_left;
    logic [31:0] ms_cnt;
    logic [31:0] prdata;
    logic pslverr;
  } owc_state_t;

endpackage

// >>> logic/owc_sync.sv
`timescale 1ns/1ns
module owc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q_mid,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } owc_sync_st_t;

  owc_sync_st_t st_r;
  owc_sync_st_t st_nxt;

  // Three stages; the first is read only by the second
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= {RST, RST, RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q_mid = st_r.s2;
  assign q = st_r.s3;

endmodule // owc_sync

// >>> logic/owc_regs.sv
// Design decision made here: the APB register port.
`timescale 1ns/1ns
`include "owc_map.svh"
module owc_regs #(
  parameter int ADDR_W = 12,
  parameter int NUM_WAKE_IN = 8,
  parameter int MS_CYCLES = `OWC_DEB_UNIT_NS / `OWC_CLK_PERIOD_NS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire owc_pkg::owc_ana_raw_t ana_raw,
  input wire logic [NUM_WAKE_IN-1:0] wake_in,
  output owc_pkg::owc_osc_ctrl_t osc_ctrl,
  output logic wake_irq
);

  // Byte addresses of the registers on the bus
  localparam logic [ADDR_W-1:0] A_FAST =
    ADDR_W'(`OWC_ADDR(`OWC_OFF_FAST_OSC));
  localparam logic [ADDR_W-1:0] A_LOWF =
    ADDR_W'(`OWC_ADDR(`OWC_OFF_LOWFREQ));
  localparam logic [ADDR_W-1:0] A_REF =
    ADDR_W'(`OWC_ADDR(`OWC_OFF_REF_TRIM));
  localparam logic [ADDR_W-1:0] A_STAT =
    ADDR_W'(`OWC_ADDR(`OWC_OFF_ANA_STAT));
  localparam logic [ADDR_W-1:0] A_WCTRL =
    ADDR_W'(`OWC_ADDR(`OWC_OFF_WAKE_CTRL));
  localparam logic [ADDR_W-1:0] A_THR =
    ADDR_W'(`OWC_ADDR(`OWC_OFF_WAKE_THR));
  localparam logic [ADDR_W-1:0] A_ICLR =
    ADDR_W'(`OWC_ADDR(`OWC_OFF_IRQ_CLR));
  localparam logic [ADDR_W-1:0] A_CNT =
    ADDR_W'(`OWC_ADDR(`OWC_OFF_WAKE_CNT));
  localparam logic [ADDR_W-1:0] A_CCLR =
    ADDR_W'(`OWC_ADDR(`OWC_OFF_CNT_CLR));
  localparam logic [ADDR_W-1:0] A_SEL =
    ADDR_W'(`OWC_ADDR(`OWC_OFF_WAKE_SEL));
  localparam logic [ADDR_W-1:0] A_POL =
    ADDR_W'(`OWC_ADDR(`OWC_OFF_WAKE_POL));

  localparam logic [31:0] MS_LAST = 32'(MS_CYCLES - 1);

  // Refuse settings the decode or the counters cannot serve
  initial begin
    if (ADDR_W < 11 || ADDR_W > 32) begin
      $error("owc_regs: ADDR_W must be 11 to 32");
    end
    if (NUM_WAKE_IN < 1 || NUM_WAKE_IN > 8) begin
      $error("owc_regs: NUM_WAKE_IN must be 1 to 8");
    end
    if (MS_CYCLES < 1) begin
      $error("owc_regs: MS_CYCLES must be at least 1");
    end
  end

  owc_pkg::owc_state_t st_r;
  owc_pkg::owc_state_t st_nxt;

  logic [8:0] stat_sync;
  logic [NUM_WAKE_IN-1:0] pin_mid;
  logic [NUM_WAKE_IN-1:0] pin_q;
  logic [NUM_WAKE_IN-1:0] pin_hit;
  logic [15:0] stat_word;
  logic setup_ph;
  logic wr_acc;
  logic mapped;
  logic [15:0] rd_word;
  logic key_rise;
  logic raw_event;
  logic ms_tick;
  logic count_event;
  logic irq_clr;
  logic cnt_clr;
  logic [7:0] count_inc;

  // Analog health flags cross into pclk before anyone reads them
  owc_sync #(
    .W(9),
    .RST(`OWC_STAT_RST)
  ) u_stat_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(ana_raw),
    .q_mid(),
    .q(stat_sync)
  );

  // Wake pins: an edge counts once stages two and three disagree
  owc_sync #(
    .W(NUM_WAKE_IN),
    .RST('0)
  ) u_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(wake_in),
    .q_mid(pin_mid),
    .q(pin_q)
  );

  // Status word layout; bit 8 and the top bits are reserved
  assign stat_word = {6'h00, stat_sync[8], 1'b0,
                      stat_sync[7:0]};

  // Per-input edge with chosen direction, only for enabled inputs
  genvar gi;
  generate
    for (gi = 0; gi < NUM_WAKE_IN; gi++) begin : g_pin
      assign pin_hit[gi] = st_r.wake_select[gi] &
                           (pin_mid[gi] != pin_q[gi]) &
                           (pin_mid[gi] ^
                            st_r.wake_edge_polarity[gi]);
    end
  endgenerate

  // Bus phases; the slave never stretches the access phase
  assign setup_ph = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  assign pready = 1'b1;

  // Address decode and read mux
  always_comb begin
    mapped = 1'b1;
    rd_word = 16'h0000;
    if (paddr == A_FAST) begin
      rd_word = st_r.fast_osc_config;
    end else if (paddr == A_LOWF) begin
      rd_word = st_r.lowfreq_rc_config;
    end else if (paddr == A_REF) begin
      rd_word = st_r.reference_trim;
    end else if (paddr == A_STAT) begin
      rd_word = stat_word;
    end else if (paddr == A_WCTRL) begin
      rd_word = st_r.wake_control;
    end else if (paddr == A_THR) begin
      rd_word = {8'h00, st_r.wake_event_threshold};
    end else if (paddr == A_ICLR) begin
      rd_word = 16'h0000;
    end else if (paddr == A_CNT) begin
      rd_word = {8'h00, st_r.wake_count};
    end else if (paddr == A_CCLR) begin
      rd_word = 16'h0000;
    end else if (paddr == A_SEL) begin
      rd_word = {8'h00, st_r.wake_select};
    end else if (paddr == A_POL) begin
      rd_word = {8'h00, st_r.wake_edge_polarity};
    end else begin
      mapped = 1'b0;
    end
  end

  // Key events: soft key on its rising edge, pins while it is low
  assign key_rise = st_r.wake_control[`OWC_WC_KEY] & ~st_r.key_prev;
  assign raw_event = key_rise |
                     ((|pin_hit) &
                      ~st_r.wake_control[`OWC_WC_KEY]);

  // Millisecond enable from a divider that restarts when a press starts the wait and counts only while it is pending
  assign ms_tick = st_r.deb_pending && (st_r.ms_cnt == MS_LAST);

  // A press counts at once without debounce, else when the wait ends
  assign count_event =
    (raw_event && !st_r.deb_pending &&
     st_r.wake_control[`OWC_WC_DEB] == 6'h00) ||
    (ms_tick && st_r.deb_left == 6'h01);

  assign irq_clr = wr_acc && mapped && paddr == A_ICLR;
  assign cnt_clr = wr_acc && mapped && paddr == A_CCLR;
  assign count_inc = st_r.wake_count + 8'h01;

  // Next state of every register
  always_comb begin
    st_nxt = st_r;
    st_nxt.key_prev = st_r.wake_control[`OWC_WC_KEY];

    // Debounce timer; presses during the wait are swallowed
    if (st_r.deb_pending) begin
      if (ms_tick) begin
        st_nxt.ms_cnt = 32'h00000000;
        st_nxt.deb_left = st_r.deb_left - 6'h01;
        if (st_r.deb_left == 6'h01) begin
          st_nxt.deb_pending = 1'b0;
        end
      end else begin
        st_nxt.ms_cnt = st_r.ms_cnt + 32'h00000001;
      end
    end else if (raw_event &&
                 st_r.wake_control[`OWC_WC_DEB] != 6'h00) begin
      st_nxt.deb_pending = 1'b1;
      st_nxt.deb_left = st_r.wake_control[`OWC_WC_DEB];
      st_nxt.ms_cnt = 32'h00000000;
    end

    // Event counter; a new event beats a same-cycle clear
    if (irq_clr || cnt_clr) begin
      st_nxt.wake_count = count_event ? 8'h01 : 8'h00;
    end else if (count_event) begin
      st_nxt.wake_count = count_inc;
    end

    // Sticky interrupt; the set wins over a same-cycle clear
    if (count_event && st_r.wake_control[`OWC_WC_IRQEN] &&
        ((irq_clr || cnt_clr) ? 8'h01 : count_inc) ==
        st_r.wake_event_threshold) begin
      st_nxt.wake_irq = 1'b1;
    end else if (irq_clr) begin
      st_nxt.wake_irq = 1'b0;
    end

    // Register writes in the access phase, reserved bits masked
    if (wr_acc && mapped) begin
      if (paddr == A_FAST) begin
        st_nxt.fast_osc_config =
          pwdata[15:0] & `OWC_FAST_MASK;
      end else if (paddr == A_LOWF) begin
        st_nxt.lowfreq_rc_config =
          pwdata[15:0] & `OWC_LOWF_MASK;
      end else if (paddr == A_REF) begin
        st_nxt.reference_trim =
          pwdata[15:0] & `OWC_REF_MASK;
      end else if (paddr == A_WCTRL) begin
        st_nxt.wake_control = pwdata[15:0] & `OWC_WCTRL_MASK;
      end else if (paddr == A_THR) begin
        st_nxt.wake_event_threshold = pwdata[7:0];
      end else if (paddr == A_SEL) begin
        st_nxt.wake_select = pwdata[7:0] & 8'(`OWC_BYTE_MASK);
      end else if (paddr == A_POL) begin
        st_nxt.wake_edge_polarity = pwdata[7:0];
      end
    end

    // Read data and error are captured in setup for the access phase
    if (setup_ph) begin
      st_nxt.prdata = {16'h0000, rd_word};
      st_nxt.pslverr = ~mapped;
    end
  end

  // Single register stage for the whole block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r.fast_osc_config <= `OWC_FAST_RST;
      st_r.lowfreq_rc_config <= `OWC_LOWF_RST;
      st_r.reference_trim <= `OWC_REF_RST;
      st_r.wake_control <= `OWC_WCTRL_RST;
      st_r.wake_event_threshold <= `OWC_BYTE_RST;
      st_r.wake_select <= `OWC_BYTE_RST;
      st_r.wake_edge_polarity <= `OWC_BYTE_RST;
      st_r.wake_count <= `OWC_BYTE_RST;
      st_r.wake_irq <= 1'b0;
      st_r.key_prev <= 1'b0;
      st_r.deb_pending <= 1'b0;
      st_r.deb_left <= 6'h00;
      st_r.ms_cnt <= 32'h00000000;
      st_r.prdata <= 32'h00000000;
      st_r.pslverr <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Read data and interrupt straight from flops; error flop gated by psel and penable
  assign prdata = st_r.prdata;
  assign pslverr = st_r.pslverr & psel & penable;
  assign wake_irq = st_r.wake_irq;

  // Field breakout towards the analog blocks
  always_comb begin
    osc_ctrl.xo_noise_filter_en =
      st_r.fast_osc_config[`OWC_FO_NOISE];
    osc_ctrl.xo_bias_hold_en =
      st_r.fast_osc_config[`OWC_FO_HOLD];
    osc_ctrl.xo_bias_current =
      st_r.fast_osc_config[`OWC_FO_CUR];
    osc_ctrl.fast_rc_freq_trim =
      st_r.fast_osc_config[`OWC_FO_RCTRIM];
    osc_ctrl.fast_rc_en = st_r.fast_osc_config[`OWC_FO_RCEN];
    osc_ctrl.slow_source_select =
      st_r.lowfreq_rc_config[`OWC_LF_SEL];
    osc_ctrl.slow_rc_x_en = st_r.lowfreq_rc_config[`OWC_LF_EN];
    osc_ctrl.slow_rc_x_extra_low =
      st_r.lowfreq_rc_config[`OWC_LF_LOW];
    osc_ctrl.slow_rc_x_bias = st_r.lowfreq_rc_config[`OWC_LF_BIAS];
    osc_ctrl.slow_rc_x_temp_ctrl = st_r.lowfreq_rc_config[`OWC_LF_TEMP];
    osc_ctrl.slow_rc_x_freq_trim =
      st_r.lowfreq_rc_config[`OWC_LF_TRIM];
    // Test shutdown is passed through as written; no hardware guard
    osc_ctrl.ref_core_shutdown_test = st_r.reference_trim[`OWC_RF_SHUT];
    // Low-voltage trim codes are not clamped, software must avoid them
    osc_ctrl.retention_reg_trim = st_r.reference_trim[`OWC_RF_RET];
    osc_ctrl.ref_bias_current_trim =
      st_r.reference_trim[`OWC_RF_IBIAS];
    osc_ctrl.ref_voltage_trim = st_r.reference_trim[`OWC_RF_VTRIM];
  end

endmodule // owc_regs

// >>> dv/owc_regs_sva.sv
`timescale 1ns/1ns
`include "owc_map.svh"
module owc_regs_sva #(
  parameter int ADDR_W = 12,
  parameter int NUM_WAKE_IN = 8,
  parameter int MS_CYCLES = 125000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire owc_pkg::owc_ana_raw_t ana_raw,
  input wire logic [NUM_WAKE_IN-1:0] wake_in,
  input wire owc_pkg::owc_osc_ctrl_t osc_ctrl,
  input wire logic wake_irq
);
  localparam logic [ADDR_W-1:0] A_FAST = ADDR_W'(`OWC_ADDR(`OWC_OFF_FAST_OSC));
  localparam logic [ADDR_W-1:0] A_LOWF = ADDR_W'(`OWC_ADDR(`OWC_OFF_LOWFREQ));
  localparam logic [ADDR_W-1:0] A_REF = ADDR_W'(`OWC_ADDR(`OWC_OFF_REF_TRIM));
  localparam logic [ADDR_W-1:0] A_STAT = ADDR_W'(`OWC_ADDR(`OWC_OFF_ANA_STAT));
  localparam logic [ADDR_W-1:0] A_WC = ADDR_W'(`OWC_ADDR(`OWC_OFF_WAKE_CTRL));
  localparam logic [ADDR_W-1:0] A_CLR = ADDR_W'(`OWC_ADDR(`OWC_OFF_IRQ_CLR));
  logic acc_w;
  logic acc_r;
  logic irq_en_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Completed transfers only; setup cycles must not count
  assign acc_w = psel && penable && pready && pwrite;
  assign acc_r = psel && penable && pready && !pwrite;

  // Shadow of the interrupt enable, since the checker sees ports only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_r <= 1'b0;
    end else if (acc_w && paddr == A_WC) begin
      irq_en_r <= pwdata[7];
    end
  end

  rst_vals_a: assert property ($rose(presetn) |->
    osc_ctrl == {10'h0a0, 13'h0178, 15'h0000})
    else $error("control outputs differ from reset values");
  fast_wr_a: assert property (acc_w && paddr == A_FAST |=>
    osc_ctrl[37:28] == $past(pwdata[9:0]))
    else $error("fast oscillator controls do not follow write");
  lowf_wr_a: assert property (acc_w && paddr == A_LOWF |=>
    osc_ctrl[27:15] == $past(pwdata[12:0]))
    else $error("low-frequency controls do not follow write");
  ref_wr_a: assert property (acc_w && paddr == A_REF |=>
    osc_ctrl[14:0] == $past(pwdata[14:0]))
    else $error("reference controls do not follow write");
  rsv_hi_a: assert property (acc_r |-> prdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  stat_rsv_a: assert property (acc_r && paddr == A_STAT |->
    prdata[15:10] == 6'h00 && !prdata[8])
    else $error("reserved status bits not zero");
  clr_read_a: assert property (acc_r && paddr == A_CLR |->
    prdata == 32'h0000_0000)
    else $error("interrupt clear location read nonzero");
  irq_en_a: assert property ($rose(wake_irq) |->
    irq_en_r || $past(irq_en_r))
    else $error("interrupt raised while disabled");
  irq_clear_a: assert property (acc_w && paddr == A_CLR && !irq_en_r
    |=> !wake_irq)
    else $error("interrupt not cleared by write");
  irq_sticky_a: assert property (wake_irq && !(acc_w && paddr == A_CLR)
    |=> wake_irq)
    else $error("interrupt dropped without clear");
endmodule // owc_regs_sva

bind owc_regs owc_regs_sva #(.ADDR_W(ADDR_W), .NUM_WAKE_IN(NUM_WAKE_IN),
  .MS_CYCLES(MS_CYCLES)) chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .ana_raw(ana_raw),
  .wake_in(wake_in), .osc_ctrl(osc_ctrl), .wake_irq(wake_irq));

// >>> dv/tb_top.sv
`timescale 1ns/1ns
`include "owc_map.svh"
module tb_top;
  localparam int MS = 10;
  localparam logic [11:0] A_FAST = 12'(`OWC_ADDR(`OWC_OFF_FAST_OSC));
  localparam logic [11:0] A_LOWF = 12'(`OWC_ADDR(`OWC_OFF_LOWFREQ));
  localparam logic [11:0] A_REF = 12'(`OWC_ADDR(`OWC_OFF_REF_TRIM));
  localparam logic [11:0] A_STAT = 12'(`OWC_ADDR(`OWC_OFF_ANA_STAT));
  localparam logic [11:0] A_WC = 12'(`OWC_ADDR(`OWC_OFF_WAKE_CTRL));
  localparam logic [11:0] A_THR = 12'(`OWC_ADDR(`OWC_OFF_WAKE_THR));
  localparam logic [11:0] A_ICLR = 12'(`OWC_ADDR(`OWC_OFF_IRQ_CLR));
  localparam logic [11:0] A_CNT = 12'(`OWC_ADDR(`OWC_OFF_WAKE_CNT));
  localparam logic [11:0] A_CCLR = 12'(`OWC_ADDR(`OWC_OFF_CNT_CLR));
  localparam logic [11:0] A_SEL = 12'(`OWC_ADDR(`OWC_OFF_WAKE_SEL));
  localparam logic [11:0] A_POL = 12'(`OWC_ADDR(`OWC_OFF_WAKE_POL));
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, wake_irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic err_v;
  owc_pkg::owc_ana_raw_t ana_raw;
  owc_pkg::owc_osc_ctrl_t osc_ctrl;
  logic [7:0] wake_in;
  int n_mismatch, compares;
  logic [31:0] pat_fast[2] = '{32'hffffffff, 32'h00005a5a};
  logic [31:0] pat_lowf[2] = '{32'hffffffff, 32'h0000a5a5};
  logic [31:0] pat_ref[2] = '{32'hffffabff, 32'h0000ab5a};
  logic [7:0] pin_seq[5] = '{8'h01, 8'h03, 8'h01, 8'h05, 8'h04};
  logic [31:0] pin_cnt[5] = '{32'h1, 32'h1, 32'h2, 32'h2, 32'h2};

  owc_regs #(.MS_CYCLES(MS)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ana_raw(ana_raw), .wake_in(wake_in), .osc_ctrl(osc_ctrl),
    .wake_irq(wake_irq));

  // 125 MHz clock
  initial pclk = 1'b0;
  always #4 pclk = ~pclk;

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One APB transfer; request held until pready is seen at an edge
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      n_mismatch++;
      $display("timeout waiting for pready");
      conclude();
    end
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input string nm, input logic [11:0] a,
                    input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(nm, exp, rd_v);
  endtask

  // Watchdog against a hang anywhere in the sequence
  initial begin
    repeat (50000) @(posedge pclk);
    n_mismatch++;
    $display("timeout of whole run");
    conclude();
  end

  initial begin
    int k;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ana_raw = 9'h090;
    wake_in = 8'h00;
    presetn = 1'b0;
    n_mismatch = 0;
    compares = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd("fast", A_FAST, 32'h00a0);
    rd("lowfreq", A_LOWF, 32'h0178);
    rd("reference", A_REF, 32'h0000);
    rd("status", A_STAT, 32'h0090);
    rd("wake ctrl", A_WC, 32'h0000);
    rd("threshold", A_THR, 32'h0000);
    rd("count", A_CNT, 32'h0000);
    $display("test reset values done");
    // Retention trim kept at the safe code 0xa, bit 14 never set
    for (k = 0; k < 2; k++) begin
      wr(A_FAST, pat_fast[k]);
      rd("fast rw", A_FAST, pat_fast[k] & `OWC_FAST_MASK);
      wr(A_LOWF, pat_lowf[k]);
      rd("lowf rw", A_LOWF, pat_lowf[k] & `OWC_LOWF_MASK);
      wr(A_REF, pat_ref[k]);
      rd("ref rw", A_REF, pat_ref[k] & `OWC_REF_MASK);
      wr(A_THR, pat_fast[k]);
      rd("thr rw", A_THR, pat_fast[k] & `OWC_BYTE_MASK);
    end
    wr(A_FAST, 32'h100);
    rd("bias hold", A_FAST, 32'h100);
    wr(A_FAST, 32'h0);
    wr(A_STAT, 32'hffffffff);
    rd("status ro", A_STAT, 32'h0090);
    rd("irq clr read", A_ICLR, 32'h0);
    wr(12'h0fc, 32'hffffffff);
    rd("unmapped", 12'h0fc, 32'h0);
    check("unmapped err", 32'h1, {31'h0, err_v});
    $display("test register access done");
    for (k = 0; k < 9; k++) begin
      ana_raw <= 9'h001 << k;
      repeat (4) @(posedge pclk);
      rd("status bit", A_STAT,
         (k == 8) ? 32'h0200 : 32'h1 << k);
    end
    ana_raw <= 9'h090;
    $display("test status bits done");
    wr(A_THR, 32'h3);
    wr(A_WC, 32'h80);
    for (k = 1; k < 4; k++) begin
      wr(A_WC, 32'hc0);
      wr(A_WC, 32'h80);
      rd("key count", A_CNT, 32'(k));
      check("irq", {31'h0, k == 3}, {31'h0, wake_irq});
    end
    wr(A_WC, 32'hc0);
    wr(A_WC, 32'hc0);
    rd("held key", A_CNT, 32'h4);
    wr(A_WC, 32'h00);
    check("irq sticky", 32'h1, {31'h0, wake_irq});
    wr(A_ICLR, 32'h1234);
    // Let the clear settle before looking at the flop output
    @(negedge pclk);
    check("irq cleared", 32'h0, {31'h0, wake_irq});
    rd("count cleared", A_CNT, 32'h0);
    wr(A_THR, 32'h1);
    wr(A_WC, 32'h40);
    wr(A_WC, 32'h00);
    check("irq disabled", 32'h0, {31'h0, wake_irq});
    $display("test soft key done");
    wr(A_CCLR, 32'h0);
    wr(A_WC, 32'h42);
    rd("debounce early", A_CNT, 32'h0);
    repeat (2 * MS + 8) @(posedge pclk);
    rd("debounce late", A_CNT, 32'h1);
    wr(A_WC, 32'h02);
    wr(A_WC, 32'h00);
    $display("test debounce done");
    wr(A_CCLR, 32'h0);
    wr(A_SEL, 32'h03);
    wr(A_POL, 32'h02);
    for (k = 0; k < 5; k++) begin
      wake_in <= pin_seq[k];
      repeat (6) @(posedge pclk);
      rd("pin count", A_CNT, pin_cnt[k]);
    end
    $display("test pin polarity done");
    conclude();
  end
endmodule // tb_top
